// ==== core/bbx_alu.sv ====
// add and and arithmetic with carry, half carry and zero
`timescale 1ns/1ns
`include "bbx_defs.svh"
module bbx_alu
  import bbx_pkg::*;
(
  bbx_alu_if.alu port_if
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  always_comb
  begin
    sum     = {1'b0, port_if.op_a} + {1'b0, port_if.op_b};
    low_sum = {1'b0, port_if.op_a[`BBX_NIBBLE_MSB:0]} + {1'b0, port_if.op_b[`BBX_NIBBLE_MSB:0]};
    port_if.result     = port_if.do_and ? (port_if.op_a & port_if.op_b) : sum[`BBX_BYTE_MSB:0];
    port_if.carry      = sum[`BBX_BYTE_MSB+1]; // see RULE_12
    port_if.half_carry = low_sum[`BBX_NIBBLE_MSB+1]; // see RULE_12
    port_if.zero       = (port_if.result == 8'h00); // see RULE_12
  end
endmodule

// ==== core/bbx_alu_if.sv ====
// operand and result bundle between executor and its arithmetic unit
`timescale 1ns/1ns
interface bbx_alu_if;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic       do_and;
  logic [7:0] result;
  logic       carry;
  logic       half_carry;
  logic       zero;
  modport core (output op_a, output op_b, output do_and,
                input result, input carry, input half_carry, input zero);
  modport alu  (input op_a, input op_b, input do_and,
                output result, output carry, output half_carry, output zero);
endinterface

// ==== core/bbx_defs.svh ====
// constants for the byte and bit instruction executor
`ifndef BBX_DEFS_SVH
`define BBX_DEFS_SVH
`define BBX_OP_ADD_LIT   3'h0
`define BBX_OP_ADD_FILE  3'h1
`define BBX_OP_AND_LIT   3'h2
`define BBX_OP_AND_FILE  3'h3
`define BBX_OP_BIT_SET   3'h4
`define BBX_OP_BIT_CLR   3'h5
`define BBX_OP_SKIP_ONE  3'h6
`define BBX_OP_SKIP_ZERO 3'h7
`define BBX_DEST_ACC     1'h0
`define BBX_DEST_FILE    1'h1
`define BBX_ACC_RESET    8'h00
`define BBX_FLAG_RESET   1'h0
`define BBX_NIBBLE_MSB   3
`define BBX_BYTE_MSB     7
`endif

// ==== core/bbx_exec.sv ====
// executes add, and, bit set/clear and bit test skip instructions
`timescale 1ns/1ns
`include "bbx_defs.svh"
// What this block does
// RULE_01: add literal adds immediate to accumulator, result to accumulator, updates c/dc/z.
// RULE_02: add file adds accumulator to addressed file register, updates c/dc/z.
// RULE_03: byte file ops: destination 0 writes accumulator, 1 writes file register.
// RULE_04: and literal ands immediate with accumulator into accumulator, only zero flag.
// RULE_05: and file ands accumulator with file register to destination, only zero flag.
// RULE_06: bit set forces selected file bit to one, no flag change.
// RULE_07: bit clear forces selected file bit to zero, no flag change.
// RULE_08: skip-if-one with bit one squashes next instruction into a no-op.
// RULE_09: skip-if-one with bit zero runs next instruction normally.
// RULE_10: skip-if-zero with bit zero squashes next instruction into a no-op.
// RULE_11: skip-if-zero with bit one runs next instruction normally.
// RULE_12: zero flags zero result; carry from bit 7, half carry from bit 3.
module bbx_exec
  import bbx_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic       instr_valid_in,
  input  wire logic [2:0] instr_op_in,
  input  wire logic [7:0] literal_in,
  input  wire logic [6:0] file_addr_in,
  input  wire logic       dest_in,
  input  wire logic [2:0] bit_sel_in,
  input  wire logic [7:0] file_rdata_in,
  output logic      [6:0] file_addr_out,
  output logic      [7:0] file_wdata_out,
  output logic            file_we_out,
  output logic      [7:0] acc_out,
  output logic            carry_out,
  output logic            half_carry_flag_out,
  output logic            zero_out,
  output logic            squash_out,
  output logic            retire_out
);
  typedef struct packed {
    logic          rst_meta;
    logic          rst_sync;
    bbx_state_type state;
    logic [7:0]    acc;
    logic          carry;
    logic          half_carry;
    logic          zero;
    logic [7:0]    fwdata;
    logic          fwe;
    logic          retire;
  } bbx_exec_state_type;

  bbx_exec_state_type st_r;
  bbx_exec_state_type st_nxt;
  bbx_alu_if          alu_bus ();
  bbx_op_type         op;
  logic               bit_val;
  logic [7:0]         bit_mask;
  logic               run;

  bbx_alu u_alu (.port_if(alu_bus.alu));

  assign op       = bbx_op_type'(instr_op_in);
  assign bit_val  = file_rdata_in[bit_sel_in];
  assign bit_mask = 8'h01 << bit_sel_in;
  assign run      = instr_valid_in && (st_r.state == BBX_RUN);

  always_comb
  begin
    alu_bus.op_a   = st_r.acc;
    alu_bus.op_b   = (op == BBX_ADD_LIT || op == BBX_AND_LIT) ? literal_in : file_rdata_in;
    alu_bus.do_and = (op == BBX_AND_LIT || op == BBX_AND_FILE);
  end

  // reset release goes through two flops; the flops themselves reset from the pin
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= '0;
      st_r.state <= BBX_RUN;
      st_r.acc   <= `BBX_ACC_RESET;
    end
    else if (!st_r.rst_sync)
    begin
      st_r.rst_meta <= 1'b1;
      st_r.rst_sync <= st_r.rst_meta;
    end
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.fwe    = 1'b0;
    st_nxt.retire = 1'b0;
    if (instr_valid_in && st_r.state == BBX_SQUASH)
    begin
      // the discarded slot retires as a no-op; nothing changes
      st_nxt.state  = BBX_RUN; // see RULE_08 see RULE_10
      st_nxt.retire = 1'b1;
    end
    else if (run)
    begin
      st_nxt.retire = 1'b1;
      case (op)
        BBX_ADD_LIT, BBX_ADD_FILE:
        begin
          st_nxt.carry      = alu_bus.carry; // see RULE_01 see RULE_02
          st_nxt.half_carry = alu_bus.half_carry;
          st_nxt.zero       = alu_bus.zero;
          if (op == BBX_ADD_LIT || dest_in == `BBX_DEST_ACC)
            st_nxt.acc = alu_bus.result; // see RULE_01 see RULE_03
          else
          begin
            st_nxt.fwdata = alu_bus.result; // see RULE_02 see RULE_03
            st_nxt.fwe    = 1'b1;
          end
        end
        BBX_AND_LIT, BBX_AND_FILE:
        begin
          st_nxt.zero = alu_bus.zero; // see RULE_04 see RULE_05
          if (op == BBX_AND_LIT || dest_in == `BBX_DEST_ACC)
            st_nxt.acc = alu_bus.result; // see RULE_04 see RULE_03
          else
          begin
            st_nxt.fwdata = alu_bus.result; // see RULE_05 see RULE_03
            st_nxt.fwe    = 1'b1;
          end
        end
        BBX_BIT_SET:
        begin
          st_nxt.fwdata = file_rdata_in | bit_mask; // see RULE_06
          st_nxt.fwe    = 1'b1;
        end
        BBX_BIT_CLR:
        begin
          st_nxt.fwdata = file_rdata_in & ~bit_mask; // see RULE_07
          st_nxt.fwe    = 1'b1;
        end
        BBX_SKIP_ONE:
          st_nxt.state = bit_val ? BBX_SQUASH : BBX_RUN; // see RULE_08 see RULE_09
        BBX_SKIP_ZRO:
          st_nxt.state = bit_val ? BBX_RUN : BBX_SQUASH; // see RULE_10 see RULE_11
        default:
          st_nxt.state = BBX_RUN;
      endcase
    end
  end

  assign file_addr_out       = file_addr_in;
  assign file_wdata_out      = st_r.fwdata;
  assign file_we_out         = st_r.fwe;
  assign acc_out             = st_r.acc;
  assign carry_out           = st_r.carry;
  assign half_carry_flag_out = st_r.half_carry;
  assign zero_out            = st_r.zero;
  assign squash_out          = (st_r.state == BBX_SQUASH);
  assign retire_out          = st_r.retire;

  // assertions stay quiet until the reset release has passed both flops
  logic rst_ok;
  assign rst_ok = st_r.rst_sync;

  sequence s_skip_taken;
    run && ((op == BBX_SKIP_ONE && bit_val) || (op == BBX_SKIP_ZRO && !bit_val));
  endsequence
  sequence s_slot_squashed;
    squash_out && !file_we_out;
  endsequence

  chk_skip_squash: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_08
    s_skip_taken |=> s_slot_squashed)
    else $error("taken skip did not squash next slot");
  chk_skip_pass: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_09
    run && op == BBX_SKIP_ONE && !bit_val |=> !squash_out)
    else $error("skip-if-one squashed on zero bit");
  chk_skipz_pass: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_11
    run && op == BBX_SKIP_ZRO && bit_val |=> !squash_out)
    else $error("skip-if-zero squashed on one bit");
  chk_squash_frozen: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_10
    squash_out && instr_valid_in |=> $stable(acc_out) && !file_we_out && !squash_out)
    else $error("squashed slot had an effect");
  chk_add_lit_sum: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_01
    run && op == BBX_ADD_LIT |=> acc_out == 8'($past(st_r.acc) + $past(literal_in)))
    else $error("add literal sum wrong");
  chk_add_file_wb: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_02
    run && op == BBX_ADD_FILE && dest_in |=> file_we_out
      && file_wdata_out == 8'($past(st_r.acc) + $past(file_rdata_in)) && $stable(acc_out))
    else $error("add file writeback wrong");
  chk_dest_acc: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_03
    run && (op == BBX_ADD_FILE || op == BBX_AND_FILE) && !dest_in |=> !file_we_out)
    else $error("destination zero wrote file");
  chk_and_flags: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_04
    run && op == BBX_AND_LIT |=> $stable(carry_out) && $stable(half_carry_flag_out)
      && acc_out == ($past(st_r.acc) & $past(literal_in)))
    else $error("and literal wrong or touched carry");
  chk_and_file_z: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_05
    run && op == BBX_AND_FILE |=> zero_out == (($past(st_r.acc) & $past(file_rdata_in)) == 8'h00))
    else $error("and file zero flag wrong");
  chk_bit_set: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_06
    run && op == BBX_BIT_SET |=> file_we_out && file_wdata_out[$past(bit_sel_in)]
      && $stable(zero_out) && $stable(carry_out))
    else $error("bit set failed");
  chk_bit_clear: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_07
    run && op == BBX_BIT_CLR |=> file_we_out && !file_wdata_out[$past(bit_sel_in)]
      && $stable(zero_out) && $stable(half_carry_flag_out))
    else $error("bit clear failed");
  chk_zero_flag: assert property (@(posedge mclk_in) disable iff (!rst_ok) // see RULE_12
    run && op == BBX_ADD_LIT |=> zero_out == (acc_out == 8'h00)
      && carry_out == ((9'($past(st_r.acc)) + 9'($past(literal_in))) > 9'h0ff))
    else $error("add flags wrong");
endmodule

// ==== core/bbx_pkg.sv ====
// types shared by the instruction executor
package bbx_pkg;
  typedef enum logic [2:0] {
    BBX_ADD_LIT  = 3'h0,
    BBX_ADD_FILE = 3'h1,
    BBX_AND_LIT  = 3'h2,
    BBX_AND_FILE = 3'h3,
    BBX_BIT_SET  = 3'h4,
    BBX_BIT_CLR  = 3'h5,
    BBX_SKIP_ONE = 3'h6,
    BBX_SKIP_ZRO = 3'h7
  } bbx_op_type;
  typedef enum logic {BBX_RUN, BBX_SQUASH} bbx_state_type;
endpackage

// ==== sim/bbx_file_model.sv ====
// file register space model facing the instruction executor
`timescale 1ns/1ns
module bbx_file_model
(
  input  wire logic       mclk_in,
  input  wire logic [6:0] file_addr_in,
  input  wire logic [7:0] file_wdata_in,
  input  wire logic       file_we_in,
  output logic      [7:0] file_rdata_out
);
  logic [7:0] mem [128];
  logic [6:0] wr_addr_r;
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 17);
    wr_addr_r = 7'h00;
  end
  // the write lands one edge late, so a back-to-back reader is handed it directly
  assign file_rdata_out = (file_we_in && wr_addr_r == file_addr_in) ? file_wdata_in
                                                                    : mem[file_addr_in];
  always @(posedge mclk_in)
  begin
    if (file_we_in)
      mem[wr_addr_r] <= file_wdata_in;
    wr_addr_r <= file_addr_in;
  end
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the byte and bit instruction executor
`timescale 1ns/1ns
module tb;
  import bbx_pkg::*;
  typedef struct packed {logic [7:0] acc; logic c; logic dc; logic z;
                         logic sq; logic we; logic [7:0] wd;} bbx_note_type;
  logic         mclk_in, rstn_in, instr_valid_in, dest_in, file_we_out;
  logic         carry_out, half_carry_flag_out, zero_out, squash_out, retire_out;
  logic   [2:0] instr_op_in, bit_sel_in;
  logic   [6:0] file_addr_in, file_addr_out;
  logic   [7:0] literal_in, file_rdata_in, file_wdata_out, acc_out;
  logic   [7:0] e_acc, mir [128];
  logic         e_c, e_dc, e_z, e_sq;
  bbx_note_type q [$];
  bbx_note_type m;
  integer       seed, failures = 0, compares = 0;

  bbx_exec dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in),
    .instr_op_in(instr_op_in), .literal_in(literal_in), .file_addr_in(file_addr_in),
    .dest_in(dest_in), .bit_sel_in(bit_sel_in), .file_rdata_in(file_rdata_in),
    .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out), .file_we_out(file_we_out),
    .acc_out(acc_out), .carry_out(carry_out), .half_carry_flag_out(half_carry_flag_out),
    .zero_out(zero_out), .squash_out(squash_out), .retire_out(retire_out));
  bbx_file_model fm_u (.mclk_in(mclk_in), .file_addr_in(file_addr_out),
    .file_wdata_in(file_wdata_out), .file_we_in(file_we_out), .file_rdata_out(file_rdata_in));

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // drive one slot and note what it must leave behind
  task automatic step(input logic v, input logic [2:0] op, input logic [7:0] k,
                      input logic [6:0] a, input logic d, input logic [2:0] b);
    logic [8:0] s;
    logic [7:0] f, o, r;
    logic       nsq, wr;
    @(negedge mclk_in);
    {instr_valid_in, instr_op_in, literal_in, file_addr_in, dest_in, bit_sel_in}
      = {v, op, k, a, d, b};
    if (v)
    begin
      f = mir[a];
      o = op[0] ? f : k;
      r = f;
      nsq = 1'b0;
      wr = !e_sq && (op == 3'h4 || op == 3'h5 || (op < 3'h4 && op[0] && d));
      if (!e_sq)
        case (op)
          3'h0, 3'h1:
          begin
            s = {1'b0, e_acc} + {1'b0, o};
            r = s[7:0];
            e_c = s[8];
            e_dc = ({1'b0, e_acc[3:0]} + {1'b0, o[3:0]}) > 5'h0f;
            e_z = (r == 8'h00);
          end
          3'h2, 3'h3:
          begin
            r = e_acc & o;
            e_z = (r == 8'h00);
          end
          3'h4: r = f | (8'h01 << b);
          3'h5: r = f & ~(8'h01 << b);
          default: nsq = f[b] ^ op[0];
        endcase
      if (!e_sq && op < 3'h4 && !(op[0] && d))
        e_acc = r;
      if (wr)
        mir[a] = r;
      e_sq = nsq;
      q.push_back({e_acc, e_c, e_dc, e_z, e_sq, wr, r});
    end
  endtask

  always @(negedge mclk_in)
    if (retire_out === 1'b1)
    begin
      if (q.size() == 0)
        chk("spare retire", 8'h01, 8'h00);
      else
      begin
        m = q.pop_front();
        chk("acc", acc_out, m.acc);
        chk("carry", carry_out, m.c);
        chk("half carry", half_carry_flag_out, m.dc);
        chk("zero", zero_out, m.z);
        chk("squash", squash_out, m.sq);
        chk("write enable", file_we_out, m.we);
        if (m.we)
          chk("write data", file_wdata_out, m.wd);
      end
    end

  task automatic do_reset();
    @(negedge mclk_in);
    rstn_in = 1'b0;
    {e_acc, e_c, e_dc, e_z, e_sq} = '0;
    repeat (4) @(negedge mclk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("reset acc", acc_out, 8'h00);
    chk("reset flags", {3'h0, carry_out, half_carry_flag_out, zero_out, squash_out,
        file_we_out}, 8'h00);
    $display("test reset done");
  endtask

  // bounded wait for every noted slot to retire
  task automatic drain();
    int n;
    n = 0;
    step(1'b0, 3'h0, 8'h00, 7'h00, 1'b0, 3'h0);
    while (q.size() != 0 && n < 10)
    begin
      @(negedge mclk_in);
      n++;
    end
    if (q.size() != 0)
    begin
      failures++;
      give_verdict();
    end
  endtask

  // low addresses are favoured so that back-to-back slots hit the same register
  task automatic run_random(input int cnt);
    logic [31:0] x;
    repeat (cnt)
    begin
      x = $random(seed);
      step(x[1:0] != 2'b00, x[4:2], x[12:5], x[21] ? x[28:22] : {3'h0, x[16:13]},
           x[17], x[20:18]);
    end
  endtask

  initial
  begin
    seed = 32'h10ccfb08;
    rstn_in = 1'b0;
    {instr_valid_in, instr_op_in, literal_in, file_addr_in, dest_in, bit_sel_in} = '0;
    for (int i = 0; i < 128; i++)
      mir[i] = 8'(i * 37 + 17);
    do_reset();
    step(1'b1, 3'h0, 8'h0f, 7'h00, 1'b0, 3'h0);
    step(1'b1, 3'h0, 8'hf1, 7'h00, 1'b0, 3'h0);
    for (int op = 0; op < 8; op++)
      for (int d = 0; d < 2; d++)
        step(1'b1, 3'(op), 8'ha5, 7'h7f, 1'(d), 3'h7);
    drain();
    $display("test directed ops done");
    run_random(800);
    drain();
    $display("test random run done");
    do_reset();
    run_random(100);
    drain();
    $display("test second reset done");
    for (int i = 0; i < 128; i++)
      chk("file contents", fm_u.mem[i], mir[i]);
    give_verdict();
  end
endmodule
